// file: rtl/abhl_alarm_log.sv
// alarm buffer and history log with an AHB-Lite register slave
// assumes one clock, synchronous inputs, single word transfers
`timescale 1ns/1ps
`include "abhl_consts.svh"
module abhl_alarm_log #(
	parameter int CYC_PER_MS = `ABHL_CYC_PER_MS
) (
	input  wire logic                 ref_clk,
	input  wire logic                 reset_n,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic                      hreadyout,
	output logic                      hresp,
	output logic [31:0]               hrdata,
	input  wire logic                 alarm_raise,
	input  wire abhl_pkg::abhl_alarm_t alarm_in,
	input  wire logic                 alarm_clear,
	input  wire logic [15:0]          clear_code,
	output logic                      alarm_ready,
	output logic                      alarm_active
);
	if (CYC_PER_MS < 2)
		$error("CYC_PER_MS too small");
	abhl_pkg::abhl_entry_t buf_q [`ABHL_BUF_SLOTS];
	abhl_pkg::abhl_entry_t hist  [`ABHL_HIST_SLOTS];
	abhl_pkg::abhl_state_t state;
	abhl_pkg::abhl_alarm_t pend;
	abhl_pkg::abhl_entry_t next_entry;
	abhl_pkg::abhl_entry_t rd_entry;
	logic [31:0] cyc_cnt;
	logic [31:0] ms_cnt;
	logic [15:0] day_cnt;
	logic [3:0]  fill;
	logic [2:0]  step;
	logic [3:0]  wp;
	logic [3:0]  next_wp;
	logic        has_pend;
	logic        xfer_req;
	logic        any_rem;
	logic        raise_ok;
	logic        clear_ok;
	logic        keep;
	logic [31:0] counter;
	logic [15:0] latest;
	logic [5:0]  index;
	logic        dp_wr;
	logic        dp_rd;
	logic [7:0]  dp_addr;
	logic        wr_zero;
	default clocking abhl_cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);
	// internal time base
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cyc_cnt <= '0;
			ms_cnt  <= '0;
			day_cnt <= '0;
		end else if (cyc_cnt == 32'(CYC_PER_MS - 1)) begin
			cyc_cnt <= '0;
			if (ms_cnt == `ABHL_MS_PER_DAY - 32'h0000_0001) begin
				ms_cnt  <= '0;
				day_cnt <= day_cnt + 16'h0001;
			end else
				ms_cnt <= ms_cnt + 32'h0000_0001;
		end else
			cyc_cnt <= cyc_cnt + 32'h0000_0001;
	end
	assign raise_ok = alarm_raise && alarm_ready;
	assign clear_ok = alarm_clear && alarm_ready;
	assign keep     = ({1'b0, step} < fill) && !buf_q[step].removed;
	assign next_wp  = wp + {3'h0, keep};
	always_comb begin
		any_rem = 1'b0;
		for (int k = 0; k < `ABHL_BUF_SLOTS; k++)
			if (4'(k) < fill && buf_q[k].removed)
				any_rem = 1'b1;
	end
	// new entry stamped with the current time
	always_comb begin
		next_entry         = '0;
		next_entry.code    = (state == abhl_pkg::ABHL_FILL) ?
			pend.code : alarm_in.code;
		next_entry.vfix    = (state == abhl_pkg::ABHL_FILL) ?
			pend.vfix : alarm_in.vfix;
		next_entry.vflt    = (state == abhl_pkg::ABHL_FILL) ?
			pend.vflt : alarm_in.vflt;
		next_entry.rx_days = day_cnt;
		next_entry.rx_ms   = ms_cnt;
		next_entry.cl_days = `ABHL_EMPTY_DAYS;
		next_entry.cl_ms   = `ABHL_EMPTY_WORD;
		next_entry.used    = 1'b1;
	end
	// sequencer for storing and transferring
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state       <= abhl_pkg::ABHL_IDLE;
			fill        <= '0;
			step        <= '0;
			wp          <= '0;
			pend        <= '0;
			has_pend    <= 1'b0;
			xfer_req    <= 1'b0;
			alarm_ready <= 1'b1;
		end else begin
			if (wr_zero)
				xfer_req <= 1'b1;
			unique case (state)
			abhl_pkg::ABHL_IDLE: begin
				if (raise_ok && fill < 4'h8) begin
					fill <= fill + 4'h1;
				end else if (raise_ok && any_rem) begin
					pend        <= alarm_in;
					has_pend    <= 1'b1;
					state       <= abhl_pkg::ABHL_MOVE;
					step        <= '0;
					wp          <= '0;
					alarm_ready <= 1'b0;
				end else if (!raise_ok && xfer_req) begin
					xfer_req    <= wr_zero;
					has_pend    <= 1'b0;
					state       <= abhl_pkg::ABHL_MOVE;
					step        <= '0;
					wp          <= '0;
					alarm_ready <= 1'b0;
				end
			end
			abhl_pkg::ABHL_MOVE: begin
				wp   <= next_wp;
				step <= step + 3'h1;
				if (step == 3'h7) begin
					fill <= next_wp;
					if (has_pend) begin
						state <= abhl_pkg::ABHL_FILL;
					end else begin
						state       <= abhl_pkg::ABHL_IDLE;
						alarm_ready <= 1'b1;
					end
				end
			end
			abhl_pkg::ABHL_FILL: begin
				fill        <= fill + 4'h1;
				has_pend    <= 1'b0;
				state       <= abhl_pkg::ABHL_IDLE;
				alarm_ready <= 1'b1;
			end
			default: begin
				state       <= abhl_pkg::ABHL_IDLE;
				alarm_ready <= 1'b1;
			end
			endcase
		end
	end
	// buffer contents
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			for (int k = 0; k < `ABHL_BUF_SLOTS; k++)
				buf_q[k] <= '0;
		end else if (state == abhl_pkg::ABHL_IDLE) begin
			if (raise_ok && fill < 4'h8)
				buf_q[fill[2:0]] <= next_entry;
			else if (raise_ok && !any_rem)
				buf_q[`ABHL_OVERWRITE] <= next_entry;
			for (int k = 0; k < `ABHL_BUF_SLOTS; k++) begin
				if (clear_ok && 4'(k) < fill && !buf_q[k].removed &&
				    buf_q[k].code == clear_code) begin
					buf_q[k].removed <= 1'b1;
					buf_q[k].cl_days <= day_cnt;
					buf_q[k].cl_ms   <= ms_cnt;
				end
			end
		end else if (state == abhl_pkg::ABHL_MOVE) begin
			if (keep)
				buf_q[wp[2:0]] <= buf_q[step];
		end else if (state == abhl_pkg::ABHL_FILL) begin
			buf_q[fill[2:0]] <= next_entry;
		end
	end
	// history: index 8 is hist[0]
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			for (int k = 0; k < `ABHL_HIST_SLOTS; k++)
				hist[k] <= '0;
		end else if (state == abhl_pkg::ABHL_MOVE &&
		             {1'b0, step} < fill && buf_q[step].removed) begin
			for (int k = `ABHL_HIST_SLOTS - 1; k > 0; k--)
				hist[k] <= hist[k - 1];
			hist[0] <= buf_q[step];
		end
	end
	// counter, latest code, status
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			counter      <= `ABHL_RST_WORD;
			latest       <= '0;
			alarm_active <= 1'b0;
		end else begin
			if (dp_wr && dp_addr == `ABHL_OFS_COUNTER)
				counter <= hwdata + {31'h0, raise_ok};
			else if (raise_ok)
				counter <= counter + 32'h0000_0001;
			if (raise_ok)
				latest <= alarm_in.code;
			alarm_active <= 1'b0;
			for (int k = 0; k < `ABHL_BUF_SLOTS; k++)
				if (4'(k) < fill && !buf_q[k].removed)
					alarm_active <= 1'b1;
		end
	end
	// AHB-Lite data phase tracking
	assign wr_zero = dp_wr && dp_addr == `ABHL_OFS_COUNTER &&
		hwdata == 32'h0000_0000;
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			dp_wr     <= 1'b0;
			dp_rd     <= 1'b0;
			dp_addr   <= '0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			dp_wr <= hsel && htrans[1] && hready && hwrite;
			dp_rd <= hsel && htrans[1] && hready && !hwrite;
			if (hsel && htrans[1] && hready)
				dp_addr <= haddr[7:0];
			hreadyout <= !(hsel && htrans[1] && hready && !hwrite);
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			index <= '0;
		else if (dp_wr && dp_addr == `ABHL_OFS_INDEX)
			index <= hwdata[5:0];
	end
	// selected entry, empty slots read as empty
	always_comb begin
		rd_entry         = '0;
		rd_entry.rx_days = `ABHL_EMPTY_DAYS;
		rd_entry.rx_ms   = `ABHL_EMPTY_WORD;
		rd_entry.cl_days = `ABHL_EMPTY_DAYS;
		rd_entry.cl_ms   = `ABHL_EMPTY_WORD;
		if (index < 6'h08) begin
			if ({1'b0, index[2:0]} < fill)
				rd_entry = buf_q[index[2:0]];
		end else if (hist[index - 6'h08].used) begin
			rd_entry = hist[index - 6'h08];
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			hrdata <= `ABHL_RST_WORD;
		end else if (dp_rd) begin
			unique case (dp_addr)
			`ABHL_OFS_STATUS:  hrdata <= {24'h0, alarm_active, 6'h0,
				!alarm_ready};
			`ABHL_OFS_COUNTER: hrdata <= counter;
			`ABHL_OFS_LATEST:  hrdata <= {16'h0, latest};
			`ABHL_OFS_INDEX:   hrdata <= {26'h0, index};
			`ABHL_OFS_CODE:    hrdata <= {16'h0, rd_entry.code};
			`ABHL_OFS_VFIX:    hrdata <= rd_entry.vfix;
			`ABHL_OFS_VFLT:    hrdata <= rd_entry.vflt;
			`ABHL_OFS_RX_DAYS: hrdata <= {16'h0, rd_entry.rx_days};
			`ABHL_OFS_RX_MS:   hrdata <= rd_entry.rx_ms;
			`ABHL_OFS_CL_DAYS: hrdata <= {16'h0, rd_entry.cl_days};
			`ABHL_OFS_CL_MS:   hrdata <= rd_entry.cl_ms;
			default:           hrdata <= `ABHL_RST_WORD;
			endcase
		end
	end
	// checks
	property p_active;
		(fill == 4'h0) |=> !alarm_active;
	endproperty
	a_active: assert property (p_active) else $error("active, empty");
	property p_count;
		(raise_ok && !dp_wr) |=> counter == $past(counter) + 32'h0000_0001;
	endproperty
	a_count: assert property (p_count) else $error("no count step");
	property p_hold;
		(!raise_ok && !dp_wr) |=> $stable(counter);
	endproperty
	a_hold: assert property (p_hold) else $error("count moved");
	property p_latest;
		raise_ok |=> latest == $past(alarm_in.code);
	endproperty
	a_latest: assert property (p_latest) else $error("latest stale");
	property p_stamp;
		(raise_ok && fill < 4'h8) |=>
			buf_q[$past(fill[2:0])].rx_ms == $past(ms_cnt);
	endproperty
	a_stamp: assert property (p_stamp) else $error("rx not stamped");
	property p_ovw;
		(raise_ok && fill == 4'h8 && !any_rem) |=>
			buf_q[6].code == $past(alarm_in.code) && fill == 4'h8;
	endproperty
	a_ovw: assert property (p_ovw) else $error("slot 6 missed");
	property p_xfer;
		(state == abhl_pkg::ABHL_IDLE && raise_ok && fill == 4'h8 &&
		 any_rem) |=> !alarm_ready [*8] ##1 !any_rem;
	endproperty
	a_xfer: assert property (p_xfer) else $error("removed left");
	property p_zero;
		wr_zero |-> ##[1:20] state == abhl_pkg::ABHL_MOVE;
	endproperty
	a_zero: assert property (p_zero) else $error("no transfer");
	property p_ms;
		1'b1 |-> ms_cnt < `ABHL_MS_PER_DAY;
	endproperty
	a_ms: assert property (p_ms) else $error("ms past day");
endmodule

// file: rtl/abhl_consts.svh
// alarm buffer and history log: offsets, fields, reset values, timing
// assumes one 40 MHz clock and a word-wide register bus
`ifndef ABHL_CONSTS_SVH
`define ABHL_CONSTS_SVH
// byte offsets of the registers
`define ABHL_OFS_STATUS   8'h00
`define ABHL_OFS_COUNTER  8'h04
`define ABHL_OFS_LATEST   8'h08
`define ABHL_OFS_INDEX    8'h0C
`define ABHL_OFS_CODE     8'h10
`define ABHL_OFS_VFIX     8'h14
`define ABHL_OFS_VFLT     8'h18
`define ABHL_OFS_RX_DAYS  8'h1C
`define ABHL_OFS_RX_MS    8'h20
`define ABHL_OFS_CL_DAYS  8'h24
`define ABHL_OFS_CL_MS    8'h28
// status word fields
`define ABHL_STAT_ACTIVE  7
`define ABHL_STAT_BUSY    0
// reset and empty values
`define ABHL_RST_WORD     32'h0000_0000
`define ABHL_EMPTY_WORD   32'hFFFF_FFFF
`define ABHL_EMPTY_DAYS   16'hFFFF
// buffer layout
`define ABHL_BUF_SLOTS    8
`define ABHL_HIST_SLOTS   56
`define ABHL_OVERWRITE    3'h6
// time base
`define ABHL_CLK_NS       25
`define ABHL_MS_NS        1000000
`define ABHL_CYC_PER_MS   (`ABHL_MS_NS / `ABHL_CLK_NS)
`define ABHL_MS_PER_DAY   32'h0526_5C00
`endif

// file: rtl/abhl_pkg.sv
// alarm buffer and history log: shared types
// assumes abhl_consts.svh for all figures
package abhl_pkg;
	typedef enum logic [1:0] {
		ABHL_IDLE = 2'b00,
		ABHL_MOVE = 2'b01,
		ABHL_FILL = 2'b10
	} abhl_state_t;
	typedef struct packed {
		logic [15:0] code;
		logic [31:0] vfix;
		logic [31:0] vflt;
	} abhl_alarm_t;
	typedef struct packed {
		logic [15:0] code;
		logic [31:0] vfix;
		logic [31:0] vflt;
		logic [15:0] rx_days;
		logic [31:0] rx_ms;
		logic [15:0] cl_days;
		logic [31:0] cl_ms;
		logic        removed;
		logic        used;
	} abhl_entry_t;
endpackage

// file: tb/abhl_host_model.sv
// host side model: single word AHB-Lite reads and writes
// assumes one slave whose hreadyout is the bus hready
`timescale 1ns/1ps
module abhl_host_model (
	input  wire logic        ref_clk,
	input  wire logic        hreadyout,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata,
	output logic             hung
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		hung = 1'b0;
	end
	// wait for hready sampled high, bounded
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (n >= 64)
			hung <= 1'b1;
	endtask
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		htrans <= 2'b10;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
		hwdata <= ~d;
	endtask
endmodule

// file: tb/test_alarm_buffer_history_log.sv
// testbench: random alarms, buffer and history checked over the bus
// assumes abhl_consts.svh offsets and a 40 MHz reference clock
`timescale 1ns/1ps
`include "abhl_consts.svh"
module test_alarm_buffer_history_log;
	logic                  ref_clk = 1'b0;
	logic                  reset_n = 1'b0;
	logic                  hsel, hwrite, hreadyout, hresp, hung;
	logic [31:0]           haddr, hwdata, hrdata, q;
	logic [1:0]            htrans;
	logic [2:0]            hsize;
	logic                  alarm_raise = 1'b0;
	logic                  alarm_clear = 1'b0;
	logic                  alarm_ready, alarm_active;
	logic [15:0]           clear_code = 16'h0000;
	logic [15:0]           last = 16'h0000;
	logic [31:0]           cnt = 32'h0000_0000;
	abhl_pkg::abhl_alarm_t alarm_in = '0;
	abhl_pkg::abhl_alarm_t bq[$], hq[$];
	bit                    br[$];
	int                    error_cnt = 0, cmp_count = 0, k, id = 0;

	always #12.5 ref_clk = ~ref_clk;

	abhl_alarm_log #(.CYC_PER_MS(4)) abhl_alarm_log_i (
		.ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .alarm_raise(alarm_raise), .alarm_in(alarm_in),
		.alarm_clear(alarm_clear), .clear_code(clear_code),
		.alarm_ready(alarm_ready), .alarm_active(alarm_active));
	abhl_host_model abhl_host_model_i (
		.ref_clk(ref_clk), .hreadyout(hreadyout), .hrdata(hrdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hung(hung));

	task automatic final_report();
		$display("errors %0d checks %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge hung) begin
		error_cnt++;
		final_report();
	end
	task automatic chk(input logic [31:0] got, exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		abhl_host_model_i.xfer(a, 1'b0, 32'h0000_0000, d);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		abhl_host_model_i.xfer(a, 1'b1, d, x);
	endtask
	task automatic wait_ready();
		int n;
		for (n = 0; n < 64; n++) begin
			#1;
			if (alarm_ready === 1'b1)
				break;
			@(posedge ref_clk);
		end
		if (n == 64) begin
			error_cnt++;
			final_report();
		end
		@(posedge ref_clk);
	endtask
	function automatic logic [15:0] nid();
		id++;
		return {8'(id), 8'($urandom)};
	endfunction
	// removed entries go to history, youngest first
	function automatic void move();
		int i = 0;
		while (i < bq.size())
			if (br[i]) begin
				hq.push_front(bq[i]);
				bq.delete(i);
				br.delete(i);
			end else
				i++;
		while (hq.size() > 56)
			hq.pop_back();
	endfunction
	task automatic fire(input bit r, input logic [15:0] c);
		abhl_pkg::abhl_alarm_t v;
		v = {c, $urandom, $urandom};
		wait_ready();
		alarm_raise <= r;
		alarm_clear <= !r;
		alarm_in <= v;
		clear_code <= c;
		@(posedge ref_clk);
		alarm_raise <= 1'b0;
		alarm_clear <= 1'b0;
		if (!r)
			foreach (bq[i]) br[i] |= (bq[i].code == c);
		else begin
			cnt++;
			last = c;
			if (bq.size() == 8 && (1'b1 inside {br}))
				move();
			if (bq.size() == 8) begin
				bq[6] = v;
				br[6] = 1'b0;
			end else begin
				bq.push_back(v);
				br.push_back(1'b0);
			end
		end
	endtask
	task automatic zero();
		int n;
		wr(`ABHL_OFS_COUNTER, 32'h0000_0000);
		cnt = 32'h0000_0000;
		move();
		for (n = 0; n < 4 && alarm_ready === 1'b1; n++)
			@(posedge ref_clk);
	endtask
	task automatic check_all();
		abhl_pkg::abhl_alarm_t e;
		logic u, r;
		logic [31:0] t;
		wait_ready();
		rd(`ABHL_OFS_COUNTER, q);
		chk(q, cnt, "counter");
		rd(`ABHL_OFS_LATEST, q);
		chk(q, {16'h0000, last}, "latest");
		rd(`ABHL_OFS_STATUS, q);
		chk(q, {24'h00_0000, (1'b0 inside {br}), 7'h00}, "status");
		chk({31'h0, alarm_active}, {31'h0, (1'b0 inside {br})}, "act");
		for (int i = 0; i < 64; i++) begin
			u = (i < 8) ? (i < bq.size()) : (i - 8 < hq.size());
			e = !u ? '0 : (i < 8) ? bq[i] : hq[i-8];
			r = u && (i >= 8 || br[i]);
			wr(`ABHL_OFS_INDEX, 32'(i));
			rd(`ABHL_OFS_CODE, q);
			chk(q, {16'h0000, e.code}, "code");
			rd(`ABHL_OFS_VFIX, q);
			chk(q, e.vfix, "fixed");
			rd(`ABHL_OFS_VFLT, q);
			chk(q, e.vflt, "float");
			rd(`ABHL_OFS_RX_DAYS, q);
			chk(q, u ? 32'h0 : 32'h0000_FFFF, "rx days");
			rd(`ABHL_OFS_RX_MS, t);
			chk({31'h0, t == 32'hFFFF_FFFF}, {31'h0, !u}, "rx ms");
			rd(`ABHL_OFS_CL_DAYS, q);
			chk(q, r ? 32'h0 : 32'h0000_FFFF, "clear days");
			rd(`ABHL_OFS_CL_MS, q);
			chk({31'h0, q == 32'hFFFF_FFFF}, {31'h0, !r}, "clear ms");
			chk({31'h0, !r || q >= t}, 32'h0000_0001, "order");
		end
	endtask

	initial begin
		void'($urandom(32'h1d5d_c4c0));
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		rd(8'h40, q);
		chk(q, 32'h0000_0000, "unmapped");
		wr(`ABHL_OFS_LATEST, 32'h0000_5A5A);
		check_all();
		for (k = 0; k < 9; k++)
			fire(1'b1, nid());
		check_all();
		fire(1'b0, bq[1].code);
		fire(1'b0, bq[3].code);
		check_all();
		fire(1'b1, nid());
		rd(`ABHL_OFS_STATUS, q);
		chk(q, 32'h0000_0081, "busy");
		chk({31'h0, alarm_ready}, 32'h0000_0000, "refusing");
		chk({31'h0, hresp}, 32'h0000_0000, "okay");
		check_all();
		cnt = $urandom | 32'h0000_0001;
		wr(`ABHL_OFS_COUNTER, cnt);
		rd(`ABHL_OFS_COUNTER, q);
		chk(q, cnt, "load");
		foreach (bq[i]) fire(1'b0, bq[i].code);
		zero();
		check_all();
		for (k = 0; k < 50; k++) begin
			fire(1'b1, nid());
			fire(1'b0, last);
			zero();
		end
		check_all();
		final_report();
	end
endmodule
